/* File: design/picr_pkg.sv */
// picr_pkg: offsets, field positions and encodings for the per-port control bank.
// assumes a byte-wide management register port and four switch ports.
package picr_pkg;
   localparam int NUM_PORTS = 4;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   // control byte offsets, one per port
   localparam logic [7:0] PORT1_OFFSET = 8'h20;
   localparam logic [7:0] PORT2_OFFSET = 8'h30;
   localparam logic [7:0] PORT3_OFFSET = 8'h40;
   localparam logic [7:0] PORT4_OFFSET = 8'h50;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;
   // field positions
   localparam int BIT_STORM = 7;
   localparam int BIT_DSCP = 6;
   localparam int BIT_DOT1P = 5;
   localparam int BIT_PRIO_HI = 4;
   localparam int BIT_PRIO_LO = 3;
   localparam int BIT_TAG_INS = 2;
   localparam int BIT_TAG_REM = 1;
   localparam int BIT_SPLIT = 0;
   // combined queue-split codes
   localparam logic [1:0] SPLIT_ONE = 2'h0;
   localparam logic [1:0] SPLIT_TWO = 2'h1;
   localparam logic [1:0] SPLIT_FOUR = 2'h2;
   localparam logic [1:0] SPLIT_RSVD = 2'h3;
   // queue arrangement seen by the scheduler
   typedef enum logic [1:0] {QMODE_ONE, QMODE_TWO, QMODE_FOUR} picr_qmode_type;
endpackage

/* File: design/picr_port_ctrl.sv */
// picr_port_ctrl: per-port control byte bank with ingress classification and egress tag decisions.
// assumes a synchronous byte register port from the management engine and per-packet
// request pulses from the ingress parser and egress path, all on ref_clk.
// Function
// - bit 7 enables broadcast storm protection
// - bit 6 enables DiffServ classification
// - bit 5 enables 802.1p classification
// - bits 4:3 give fallback queue
// - all enabled: OR of 802.1p and DSCP
// - bit 2 inserts tag on untagged packets
// - already tagged packets never get second tag
// - inserted VID is ingress port default VID
// - bit 1 strips tag from tagged packets
// - untagged packets pass unchanged under removal
// - split code is global bit, bit 0
// - code 10 selects four queues
// - code 01 selects two queues
// - code 00 selects single queue
// - identical bytes at 0x20..0x50, reset zero
`timescale 1ns/10ps
module picr_port_ctrl #(
   parameter int NUM_PORTS = picr_pkg::NUM_PORTS,
   parameter int VID_W = 12
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // register port
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   output logic reg_rvalid,
   // global queue-split bits, one per port
   input wire logic [NUM_PORTS-1:0] global_split,
   // ingress classification request
   input wire logic cls_req,
   input wire logic [1:0] cls_port,
   input wire logic cls_is_bcast,
   input wire logic cls_dscp_ok,
   input wire logic [1:0] cls_dscp_prio,
   input wire logic cls_dot1p_ok,
   input wire logic [1:0] cls_dot1p_prio,
   output logic cls_valid,
   output logic [1:0] cls_queue,
   output logic cls_storm_check,
   // egress tag request
   input wire logic eg_req,
   input wire logic [1:0] eg_out_port,
   input wire logic [1:0] eg_in_port,
   input wire logic eg_rx_tagged,
   input wire logic [NUM_PORTS*VID_W-1:0] port_default_vid,
   output logic eg_valid,
   output logic eg_insert,
   output logic eg_strip,
   output logic [VID_W-1:0] eg_vid,
   // per-port controls to the datapath
   output logic [NUM_PORTS-1:0] storm_en,
   output logic [2*NUM_PORTS-1:0] queue_mode,
   output logic [NUM_PORTS-1:0] split_reserved
);

   typedef struct packed {
      logic [NUM_PORTS-1:0][7:0] ctrl;
      logic [7:0] rdata;
      logic rvalid;
      logic cvalid;
      logic [1:0] cqueue;
      logic cstorm;
      logic evalid;
      logic eins;
      logic estrip;
      logic [VID_W-1:0] evid;
   } picr_state_type;

   picr_state_type st;
   picr_state_type next_st;

   // address decode, shared by read and write paths
   function automatic logic [NUM_PORTS:0] decode(input logic [7:0] a);
      logic [NUM_PORTS:0] hit;
      hit = '0;
      case (a)
         picr_pkg::PORT1_OFFSET: hit[0] = 1'h1;
         picr_pkg::PORT2_OFFSET: hit[1] = 1'h1;
         picr_pkg::PORT3_OFFSET: hit[2] = 1'h1;
         picr_pkg::PORT4_OFFSET: hit[3] = 1'h1;
         default: hit[NUM_PORTS] = 1'h1;
      endcase
      return hit;
   endfunction

   logic [NUM_PORTS:0] wr_hit;
   logic [NUM_PORTS:0] rd_hit;
   logic [7:0] cls_ctrl;
   logic [7:0] eg_ctrl;
   logic [1:0] or_prio;

   assign wr_hit = decode(reg_addr);
   assign rd_hit = decode(reg_addr);
   assign cls_ctrl = st.ctrl[cls_port];
   assign eg_ctrl = st.ctrl[eg_out_port];
   assign or_prio = cls_dot1p_prio | cls_dscp_prio;

   // queue arrangement for one combined split code
   function automatic logic [1:0] qmode_of(input logic [1:0] code);
      logic [1:0] mode;
      mode = picr_pkg::QMODE_ONE;
      case (code)
         picr_pkg::SPLIT_FOUR: mode = picr_pkg::QMODE_FOUR;
         picr_pkg::SPLIT_TWO: mode = picr_pkg::QMODE_TWO;
         // reserved code falls back to one queue so nothing is reordered
         default: mode = picr_pkg::QMODE_ONE;
      endcase
      return mode;
   endfunction

   // per-port static controls, one generate slice per port
   genvar gp;
   generate
      for (gp = 0; gp < NUM_PORTS; gp++)
      begin : g_port
         logic [1:0] code;
         assign code = {global_split[gp], st.ctrl[gp][picr_pkg::BIT_SPLIT]};
         assign storm_en[gp] = st.ctrl[gp][picr_pkg::BIT_STORM];
         assign split_reserved[gp] = (code == picr_pkg::SPLIT_RSVD);
         assign queue_mode[2*gp +: 2] = qmode_of(code);

         // split decode per port, judged from the raw bits so a decode slip shows
         a_four_queues: assert property (@(posedge ref_clk) disable iff (!rst_n)
            global_split[gp] && !st.ctrl[gp][picr_pkg::BIT_SPLIT] |-> queue_mode[2*gp +: 2] == picr_pkg::QMODE_FOUR)
            else $error("four-queue split wrong");
         a_two_queues: assert property (@(posedge ref_clk) disable iff (!rst_n)
            !global_split[gp] && st.ctrl[gp][picr_pkg::BIT_SPLIT] |-> queue_mode[2*gp +: 2] == picr_pkg::QMODE_TWO)
            else $error("two-queue split wrong");
         a_one_queue: assert property (@(posedge ref_clk) disable iff (!rst_n)
            !global_split[gp] && !st.ctrl[gp][picr_pkg::BIT_SPLIT] |-> queue_mode[2*gp +: 2] == picr_pkg::QMODE_ONE)
            else $error("single queue wrong");
         a_reserved_flag: assert property (@(posedge ref_clk) disable iff (!rst_n)
            global_split[gp] && st.ctrl[gp][picr_pkg::BIT_SPLIT] |-> split_reserved[gp])
            else $error("reserved split code not flagged");
         a_storm_follow: assert property (@(posedge ref_clk) disable iff (!rst_n)
            reg_wr && wr_hit[gp] |=> storm_en[gp] == $past(reg_wdata[picr_pkg::BIT_STORM]))
            else $error("storm enable does not follow write");
      end
   endgenerate

   // next-state logic
   always_comb
   begin
      next_st = st;
      next_st.rvalid = reg_rd;
      next_st.cvalid = cls_req;
      next_st.evalid = eg_req;
      // register writes, identical layout per port
      for (int i = 0; i < NUM_PORTS; i++)
      begin
         if (reg_wr && wr_hit[i])
         begin
            next_st.ctrl[i] = reg_wdata;
         end
      end
      // register reads; unmapped reads zero
      if (reg_rd)
      begin
         next_st.rdata = picr_pkg::UNMAPPED_READ;
         for (int i = 0; i < NUM_PORTS; i++)
         begin
            if (rd_hit[i])
            begin
               next_st.rdata = st.ctrl[i];
            end
         end
      end
      // ingress classification; explicit methods override the port priority
      if (cls_req)
      begin
         next_st.cstorm = cls_is_bcast && cls_ctrl[picr_pkg::BIT_STORM];
         next_st.cqueue = cls_ctrl[picr_pkg::BIT_PRIO_HI:picr_pkg::BIT_PRIO_LO];
         if (cls_ctrl[picr_pkg::BIT_DSCP] && cls_dscp_ok && cls_ctrl[picr_pkg::BIT_DOT1P] && cls_dot1p_ok)
         begin
            next_st.cqueue = or_prio;
         end
         else if (cls_ctrl[picr_pkg::BIT_DSCP] && cls_dscp_ok)
         begin
            next_st.cqueue = cls_dscp_prio;
         end
         else if (cls_ctrl[picr_pkg::BIT_DOT1P] && cls_dot1p_ok)
         begin
            next_st.cqueue = cls_dot1p_prio;
         end
      end
      // egress tag decision, by output port's control byte
      if (eg_req)
      begin
         next_st.eins = eg_ctrl[picr_pkg::BIT_TAG_INS] && !eg_rx_tagged;
         next_st.estrip = eg_ctrl[picr_pkg::BIT_TAG_REM] && eg_rx_tagged;
         next_st.evid = port_default_vid[eg_in_port*VID_W +: VID_W];
      end
   end

   // state register, synchronous reset
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         st <= '0;
      end
      else
      begin
         st <= next_st;
      end
   end

   assign reg_rdata = st.rdata;
   assign reg_rvalid = st.rvalid;
   assign cls_valid = st.cvalid;
   assign cls_queue = st.cqueue;
   assign cls_storm_check = st.cstorm;
   assign eg_valid = st.evalid;
   assign eg_insert = st.eins;
   assign eg_strip = st.estrip;
   assign eg_vid = st.evid;

   // assertions
   // readback: a write to port 1, one quiet cycle, then a read of the same byte
   sequence s_write_p1;
      reg_wr && reg_addr == picr_pkg::PORT1_OFFSET;
   endsequence

   sequence s_quiet_bus;
      !reg_wr;
   endsequence

   sequence s_read_p1;
      reg_rd && !reg_wr && reg_addr == picr_pkg::PORT1_OFFSET;
   endsequence

   a_write_readback: assert property (@(posedge ref_clk) disable iff (!rst_n)
      s_write_p1 ##1 s_quiet_bus ##1 s_read_p1 |=> reg_rdata == $past(reg_wdata, 3))
      else $error("port 1 byte readback mismatch");

   // register bus answers; software counts reg_rvalid, so a stuck pulse would double-count
   a_read_answer: assert property (@(posedge ref_clk) disable iff (!rst_n)
      reg_rd |=> reg_rvalid)
      else $error("read not answered");

   a_rvalid_pulse: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !reg_rd |=> !reg_rvalid)
      else $error("read answer without read");

   a_rdata_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !reg_rd |=> $stable(reg_rdata))
      else $error("read data moved without read");

   a_unmapped_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
      reg_rd && rd_hit[NUM_PORTS] |=> reg_rdata == picr_pkg::UNMAPPED_READ)
      else $error("unmapped read not zero");

   a_unmapped_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
      reg_wr && wr_hit[NUM_PORTS] |=> $stable(st.ctrl))
      else $error("unmapped write changed a byte");

   a_reset_zero: assert property (@(posedge ref_clk)
      !rst_n |=> st.ctrl == {NUM_PORTS{picr_pkg::CTRL_RESET}})
      else $error("control bytes not cleared by reset");

   // classification; the queue pick is the one field the scheduler cannot sanity-check
   a_cls_answer: assert property (@(posedge ref_clk) disable iff (!rst_n)
      cls_req |=> cls_valid)
      else $error("classification not answered");

   a_cls_pulse: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !cls_req |=> !cls_valid)
      else $error("classification answer without request");

   a_cls_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !cls_req |=> $stable(cls_queue) && $stable(cls_storm_check))
      else $error("classification result moved without request");

   a_storm_set: assert property (@(posedge ref_clk) disable iff (!rst_n)
      cls_req && cls_is_bcast && cls_ctrl[picr_pkg::BIT_STORM] |=> cls_storm_check)
      else $error("storm check missing on broadcast");

   a_storm_gate: assert property (@(posedge ref_clk) disable iff (!rst_n)
      cls_req && !cls_ctrl[picr_pkg::BIT_STORM] |=> !cls_storm_check)
      else $error("storm check without enable");

   a_fallback_queue: assert property (@(posedge ref_clk) disable iff (!rst_n)
      cls_req && !(cls_ctrl[picr_pkg::BIT_DSCP] && cls_dscp_ok) && !(cls_ctrl[picr_pkg::BIT_DOT1P] && cls_dot1p_ok)
      |=> cls_queue == $past(cls_ctrl[picr_pkg::BIT_PRIO_HI:picr_pkg::BIT_PRIO_LO]))
      else $error("fallback queue wrong");

   a_or_prio: assert property (@(posedge ref_clk) disable iff (!rst_n)
      cls_req && cls_ctrl[picr_pkg::BIT_DSCP] && cls_ctrl[picr_pkg::BIT_DOT1P] && cls_dscp_ok && cls_dot1p_ok
      |=> cls_valid && cls_queue == $past(cls_dot1p_prio | cls_dscp_prio))
      else $error("combined priority wrong");

   a_dscp_only: assert property (@(posedge ref_clk) disable iff (!rst_n)
      cls_req && cls_ctrl[picr_pkg::BIT_DSCP] && cls_dscp_ok && !cls_ctrl[picr_pkg::BIT_DOT1P]
      |=> cls_queue == $past(cls_dscp_prio))
      else $error("dscp queue wrong");

   a_dot1p_only: assert property (@(posedge ref_clk) disable iff (!rst_n)
      cls_req && cls_ctrl[picr_pkg::BIT_DOT1P] && cls_dot1p_ok && !cls_ctrl[picr_pkg::BIT_DSCP]
      |=> cls_queue == $past(cls_dot1p_prio))
      else $error("802.1p queue wrong");

   // egress tag decisions follow the output port, the vid follows the input port
   a_eg_answer: assert property (@(posedge ref_clk) disable iff (!rst_n)
      eg_req |=> eg_valid)
      else $error("egress not answered");

   a_eg_pulse: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !eg_req |=> !eg_valid)
      else $error("egress answer without request");

   a_eg_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !eg_req |=> $stable(eg_vid) && $stable(eg_insert) && $stable(eg_strip))
      else $error("egress result moved without request");

   a_no_double_tag: assert property (@(posedge ref_clk) disable iff (!rst_n)
      eg_req && eg_rx_tagged |=> eg_valid && !eg_insert)
      else $error("second tag inserted");

   a_insert_tag: assert property (@(posedge ref_clk) disable iff (!rst_n)
      eg_req && !eg_rx_tagged && eg_ctrl[picr_pkg::BIT_TAG_INS] |=> eg_insert)
      else $error("tag not inserted");

   a_insert_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
      eg_req && !eg_ctrl[picr_pkg::BIT_TAG_INS] |=> !eg_insert)
      else $error("tag inserted without enable");

   a_ingress_vid: assert property (@(posedge ref_clk) disable iff (!rst_n)
      eg_req |=> eg_vid == $past(port_default_vid[eg_in_port*VID_W +: VID_W]))
      else $error("inserted vid not from ingress port");

   a_strip_tag: assert property (@(posedge ref_clk) disable iff (!rst_n)
      eg_req && eg_rx_tagged && eg_ctrl[picr_pkg::BIT_TAG_REM] |=> eg_strip)
      else $error("tag not stripped");

   a_strip_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
      eg_req && !eg_ctrl[picr_pkg::BIT_TAG_REM] |=> !eg_strip)
      else $error("tag stripped without enable");

   a_untagged_kept: assert property (@(posedge ref_clk) disable iff (!rst_n)
      eg_req && !eg_rx_tagged |=> !eg_strip)
      else $error("untagged packet stripped");

endmodule

/* File: tb/picr_port_ctrl_tb.sv */
// picr_port_ctrl_tb: directed bench for the per-port control byte bank.
// assumes picr_pkg and picr_port_ctrl compiled first; the bench drives every dut input.
`timescale 1ns/10ps
module picr_port_ctrl_tb;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic reg_wr = 1'b0, reg_rd = 1'b0, reg_rvalid;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
   logic [3:0] global_split = 4'h0, storm_en, split_reserved;
   logic cls_req = 1'b0, cls_is_bcast = 1'b0, cls_dscp_ok = 1'b0, cls_dot1p_ok = 1'b0;
   logic [1:0] cls_port = 2'h0, cls_dscp_prio = 2'h0, cls_dot1p_prio = 2'h0, cls_queue;
   logic cls_valid, cls_storm_check, eg_valid, eg_insert, eg_strip;
   logic eg_req = 1'b0, eg_rx_tagged = 1'b0;
   logic [1:0] eg_out_port = 2'h0, eg_in_port = 2'h0;
   logic [11:0] eg_vid;
   logic [7:0] queue_mode;
   // distinct default vids so a wrong port pick shows up
   logic [47:0] port_default_vid = {12'h444, 12'h333, 12'h222, 12'h111};
   int err_count = 0;
   int checks = 0;

   picr_port_ctrl #(.NUM_PORTS(4), .VID_W(12)) i_dut (
      .ref_clk(ref_clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .global_split(global_split),
      .cls_req(cls_req), .cls_port(cls_port), .cls_is_bcast(cls_is_bcast), .cls_dscp_ok(cls_dscp_ok),
      .cls_dscp_prio(cls_dscp_prio), .cls_dot1p_ok(cls_dot1p_ok), .cls_dot1p_prio(cls_dot1p_prio),
      .cls_valid(cls_valid), .cls_queue(cls_queue), .cls_storm_check(cls_storm_check), .eg_req(eg_req),
      .eg_out_port(eg_out_port), .eg_in_port(eg_in_port), .eg_rx_tagged(eg_rx_tagged),
      .port_default_vid(port_default_vid), .eg_valid(eg_valid), .eg_insert(eg_insert), .eg_strip(eg_strip),
      .eg_vid(eg_vid), .storm_en(storm_en), .queue_mode(queue_mode), .split_reserved(split_reserved));

   // 50 MHz clock
   always #10 ref_clk = ~ref_clk;

   function automatic logic [7:0] addr_of(input int i);
      return 8'h20 + 8'(i * 16);
   endfunction

   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic give_verdict();
      $display("errors %0d checks %0d", err_count, checks);
      if (err_count == 0 && checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // one write strobe, released at the next edge
   task automatic reg_write(input logic [7:0] addr, input logic [7:0] data);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= addr;
      reg_wdata <= data;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask

   // read answer lands one edge after the strobe
   task automatic reg_read(input logic [7:0] addr, input logic [7:0] exp);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= addr;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1;
      chk("reg_rvalid", 16'h1, {15'h0, reg_rvalid});
      chk("reg_rdata", {8'h0, exp}, {8'h0, reg_rdata});
   endtask

   // pkt: bcast, dscp_ok, dscp_prio, dot1p_ok, dot1p_prio; exp: storm, queue
   task automatic classify(input logic [1:0] port, input logic [6:0] pkt, input logic [2:0] exp);
      @(posedge ref_clk);
      cls_req <= 1'b1;
      cls_port <= port;
      {cls_is_bcast, cls_dscp_ok, cls_dscp_prio, cls_dot1p_ok, cls_dot1p_prio} <= pkt;
      @(posedge ref_clk);
      cls_req <= 1'b0;
      #1;
      chk("cls_valid", 16'h1, {15'h0, cls_valid});
      chk("cls_storm_queue", {13'h0, exp}, {13'h0, cls_storm_check, cls_queue});
   endtask

   // exp: insert, strip, vid
   task automatic egress(input logic [1:0] op, input logic [1:0] ip, input logic tg, input logic [13:0] exp);
      @(posedge ref_clk);
      eg_req <= 1'b1;
      eg_out_port <= op;
      eg_in_port <= ip;
      eg_rx_tagged <= tg;
      @(posedge ref_clk);
      eg_req <= 1'b0;
      #1;
      chk("eg_valid", 16'h1, {15'h0, eg_valid});
      chk("eg_ins_strip_vid", {2'h0, exp}, {2'h0, eg_insert, eg_strip, eg_vid});
   endtask

   task automatic t_reset();
      for (int i = 0; i < 4; i++)
         reg_read(addr_of(i), 8'h00);
      chk("storm_en", 16'h0, {12'h0, storm_en});
      chk("queue_mode", 16'h0, {8'h0, queue_mode});
   endtask

   // every byte independent; unmapped write lost, unmapped read zero
   task automatic t_regs();
      reg_write(addr_of(0), 8'h3C);
      reg_read(addr_of(0), 8'h3C);
      for (int i = 0; i < 4; i++)
         reg_write(addr_of(i), 8'hA5 ^ 8'(i));
      reg_write(8'h21, 8'hFF);
      for (int i = 0; i < 4; i++)
         reg_read(addr_of(i), 8'hA5 ^ 8'(i));
      reg_read(8'h21, 8'h00);
      chk("storm_en", 16'hF, {12'h0, storm_en});
      chk("queue_mode", 16'h11, {8'h0, queue_mode});
   endtask

   task automatic t_classify();
      reg_write(addr_of(1), 8'hF8);
      classify(2'h1, 7'b1101110, 3'b111);
      classify(2'h1, 7'b0101010, 3'b001);
      classify(2'h1, 7'b0000110, 3'b010);
      classify(2'h1, 7'b1001010, 3'b111);
      reg_write(addr_of(1), 8'h10);
      classify(2'h1, 7'b1101110, 3'b010);
      reg_write(addr_of(1), 8'h40);
      classify(2'h1, 7'b0101110, 3'b001);
   endtask

   task automatic t_egress();
      reg_write(addr_of(2), 8'h04);
      egress(2'h2, 2'h0, 1'b0, {2'b10, 12'h111});
      egress(2'h2, 2'h1, 1'b1, {2'b00, 12'h222});
      reg_write(addr_of(2), 8'h02);
      egress(2'h2, 2'h3, 1'b1, {2'b01, 12'h444});
      egress(2'h2, 2'h0, 1'b0, {2'b00, 12'h111});
   endtask

   // all four combined codes on port 4; 11 is the software error case
   task automatic t_split();
      logic [1:0] code;
      for (int c = 0; c < 4; c++)
      begin
         code = 2'(c);
         global_split <= {code[1], 3'h0};
         reg_write(addr_of(3), {7'h0, code[0]});
         @(posedge ref_clk);
         #1;
         chk("queue_mode", {14'h0, (code == 2'h3) ? 2'h0 : code}, {14'h0, queue_mode[7:6]});
         chk("split_reserved", {15'h0, code == 2'h3}, {15'h0, split_reserved[3]});
      end
   endtask

   // a run of under a hundred cycles; far longer means a hang
   initial
   begin
      repeat (3000) @(posedge ref_clk);
      err_count++;
      give_verdict();
   end

   initial
   begin
      repeat (16) @(posedge ref_clk);
      rst_n <= 1'b1;
      t_reset();
      t_regs();
      t_classify();
      t_egress();
      t_split();
      give_verdict();
   end
endmodule
